// >>> rtl/atsd_pkg.sv
package atsd_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int unsigned ADR_W  = 10;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SEL_W  = 4;
   localparam int unsigned REG_W  = 8;

   // ------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_TRIM_B   = 8'h7F;
   localparam logic [7:0] IDX_TRIM_C   = 8'h80;
   localparam logic [7:0] IDX_TRIM_D   = 8'h81;
   localparam logic [7:0] IDX_OVERLAP  = 8'h9A;
   localparam logic [7:0] IDX_STEER    = 8'h9B;
   localparam logic [7:0] IDX_DITHER   = 8'h9D;
   localparam logic [7:0] IDX_STATUS   = 8'hA0;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned DLY_W         = 5;
   localparam int unsigned DLY_MSB       = 4;
   localparam int unsigned DITH_EN_BIT   = 0;
   localparam int unsigned DITH_AMP_BIT  = 1;
   localparam int unsigned DITH_RND_BIT  = 2;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_OVL_BIT  = 1;
   localparam int unsigned STAT_CAL_BIT  = 2;
   localparam logic [DLY_W-1:0] OVERLAP_RESET = 5'h08;
   localparam logic [DLY_W-1:0] STEER_RESET   = 5'h07;
   localparam logic [2:0]       DITHER_RESET  = 3'h0;

   // ------------------------------------------------------------
   // Timing: overlap lasts BASE + MULT * field core clock cycles
   // ------------------------------------------------------------
   localparam int unsigned OVL_CNT_W = 7;
   localparam logic [OVL_CNT_W-1:0] OVERLAP_BASE = 7'h04;
   localparam int unsigned OVERLAP_MULT_SHIFT = 1;
   localparam int unsigned STEER_DEPTH = 32;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic rounding;
      logic amplitude;
      logic enable;
   } atsd_dither_s;

   typedef struct packed {
      logic [DLY_W-1:0] overlap;
      logic [DLY_W-1:0] steer;
   } atsd_swap_cfg_s;

   // Number of core clock cycles in which both cores sample one input.
   function automatic logic [OVL_CNT_W-1:0] overlapCycles(input logic [DLY_W-1:0] dly);
      overlapCycles = OVERLAP_BASE + (OVL_CNT_W'(dly) << OVERLAP_MULT_SHIFT);
   endfunction

endpackage

// >>> rtl/atsd_swap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module atsd_swap_timer (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         reset,
   // Settings already taken into the core domain
   input  wire atsd_pkg::atsd_swap_cfg_s     cfg,
   // Swap control from the calibration sequencer
   input  wire logic                         swapStart,
   input  wire logic                         steerSelRaw,
   // Results
   output logic                              overlapActive,
   output logic                              swapBusy,
   output logic                              steerSel
);
   import atsd_pkg::*;

   logic [OVL_CNT_W-1:0]   ovlCnt_q;
   logic [DLY_W-1:0]       steerDly_q;
   logic [DLY_W:0]         tailCnt_q;
   logic [STEER_DEPTH-1:0] hist_q;
   logic                   delayedSel;

   // ------------------------------------------------------------
   // Overlap window
   // ------------------------------------------------------------
   // The length is latched at start so a write mid-swap cannot stretch it.
   always_ff @(posedge clock) begin
      if (reset) begin
         ovlCnt_q      <= '0;
         overlapActive <= 1'b0;
      end else if (swapStart && !swapBusy) begin
         ovlCnt_q      <= overlapCycles(cfg.overlap) - OVL_CNT_W'(1);
         overlapActive <= 1'b1;
      end else if (overlapActive) begin
         if (ovlCnt_q == '0) begin
            overlapActive <= 1'b0;
         end else begin
            ovlCnt_q <= ovlCnt_q - OVL_CNT_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Swap in progress: overlap plus the steering delay tail
   // ------------------------------------------------------------
   // The tail keeps the delayed select in force until the late change lands.
   always_ff @(posedge clock) begin
      if (reset) begin
         swapBusy   <= 1'b0;
         steerDly_q <= '0;
         tailCnt_q  <= '0;
      end else if (swapStart && !swapBusy) begin
         swapBusy   <= 1'b1;
         steerDly_q <= cfg.steer;
         tailCnt_q  <= {1'b0, cfg.steer};
      end else if (swapBusy && !overlapActive) begin
         if (tailCnt_q == '0) begin
            swapBusy <= 1'b0;
         end else begin
            tailCnt_q <= tailCnt_q - (DLY_W+1)'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Steering select delay line
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         hist_q <= '0;
      end else begin
         hist_q <= {hist_q[STEER_DEPTH-2:0], steerSelRaw};
      end
   end

   // Tap zero means no added delay.
   always_comb begin
      if (steerDly_q == '0) begin
         delayedSel = steerSelRaw;
      end else begin
         delayedSel = hist_q[steerDly_q - DLY_W'(1)];
      end
   end

   // Delay applies only inside a swap; outside it the select passes straight.
   always_ff @(posedge clock) begin
      if (reset) begin
         steerSel <= 1'b0;
      end else begin
         steerSel <= swapBusy ? delayedSel : steerSelRaw;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/atsd_trim_swap_dither_regs.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module atsd_trim_swap_dither_regs #(
   parameter int unsigned TRIM_W = 8
) (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            reset,
   // Wishbone slave
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [atsd_pkg::ADR_W-1:0]      wb_adr_i,
   input  wire logic [atsd_pkg::SEL_W-1:0]      wb_sel_i,
   input  wire logic [atsd_pkg::DATA_W-1:0]     wb_dat_i,
   output logic      [atsd_pkg::DATA_W-1:0]     wb_dat_o,
   output logic                                 wb_ack_o,
   // Factory fuse store
   input  wire logic [TRIM_W-1:0]               fuseTrimB,
   input  wire logic [TRIM_W-1:0]               fuseTrimC,
   input  wire logic [TRIM_W-1:0]               fuseTrimD,
   // Calibration sequencer
   input  wire logic                            calEnable,
   input  wire logic                            swapStart,
   input  wire logic                            steerSelRaw,
   // Analog and core controls
   output logic      [TRIM_W-1:0]               terminationTrimB,
   output logic      [TRIM_W-1:0]               terminationTrimC,
   output logic      [TRIM_W-1:0]               terminationTrimD,
   output atsd_pkg::atsd_dither_s               ditherControl,
   output logic                                 swapOverlap,
   output logic                                 swapBusy,
   output logic                                 steerSel
);
   import atsd_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [TRIM_W-1:0]  trimB_q;
   logic [TRIM_W-1:0]  trimC_q;
   logic [TRIM_W-1:0]  trimD_q;
   logic [DLY_W-1:0]   overlapDly_q;
   logic [DLY_W-1:0]   steerDly_q;
   atsd_dither_s       dither_q;
   atsd_swap_cfg_s     coreCfg_q;
   atsd_dither_s       coreDither_q;
   logic               ack_q;
   logic [DATA_W-1:0]  rdata_q;
   logic [DATA_W-1:0]  rdata_d;
   logic               busReq;
   logic               wrCommit;
   logic [7:0]         regIdx;
   logic               idxOk;
   logic [7:0]         wbyte;
   logic               timerOverlap;
   logic               timerBusy;
   logic               timerSel;

   // Index from a byte address; unaligned low bits are ignored.
   function automatic logic [7:0] wordIndex(input logic [ADR_W-1:0] adr);
      wordIndex = adr[9:2];
   endfunction

   // Zero-extend an 8-bit register image onto the data bus.
   function automatic logic [DATA_W-1:0] busWord(input logic [REG_W-1:0] v);
      busWord = {{(DATA_W-REG_W){1'b0}}, v};
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Every access is answered, mapped or not, so a stray address cannot hang the bus.
   assign busReq   = wb_cyc_i && wb_stb_i;
   assign regIdx   = wordIndex(wb_adr_i);
   assign wbyte    = wb_dat_i[REG_W-1:0];
   // A write lands on the edge at which the master samples the ack.
   assign wrCommit = busReq && wb_we_i && ack_q && wb_sel_i[0] && idxOk;

   always_comb begin
      case (regIdx)
         IDX_TRIM_B, IDX_TRIM_C, IDX_TRIM_D,
         IDX_OVERLAP, IDX_STEER, IDX_DITHER: begin
            idxOk = 1'b1;
         end
         default: begin
            idxOk = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Acknowledge
   // ------------------------------------------------------------
   // One wait state, then ack for one cycle; it drops even if the master holds stb.
   always_ff @(posedge clock) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busReq && !ack_q;
      end
   end

   assign wb_ack_o = ack_q;

   // ------------------------------------------------------------
   // Termination trims
   // ------------------------------------------------------------
   // Reset captures the fuse image; the reset is synchronous so taking a port is safe.
   always_ff @(posedge clock) begin
      if (reset) begin
         trimB_q <= fuseTrimB;
         trimC_q <= fuseTrimC;
         trimD_q <= fuseTrimD;
      end else if (wrCommit) begin
         case (regIdx)
            IDX_TRIM_B: begin
               trimB_q <= wbyte[TRIM_W-1:0];
            end
            IDX_TRIM_C: begin
               trimC_q <= wbyte[TRIM_W-1:0];
            end
            IDX_TRIM_D: begin
               trimD_q <= wbyte[TRIM_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Swap delays
   // ------------------------------------------------------------
   // Only bits 4:0 are stored; reserved bits 7:5 are dropped and read zero.
   // The overlap value is not locked against calibration; software keeps clear of it.
   always_ff @(posedge clock) begin
      if (reset) begin
         overlapDly_q <= OVERLAP_RESET;
         steerDly_q   <= STEER_RESET;
      end else if (wrCommit) begin
         if (regIdx == IDX_OVERLAP) begin
            overlapDly_q <= wbyte[DLY_MSB:0];
         end
         if (regIdx == IDX_STEER) begin
            steerDly_q <= wbyte[DLY_MSB:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Dither control
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         dither_q <= atsd_dither_s'(DITHER_RESET);
      end else if (wrCommit && regIdx == IDX_DITHER) begin
         dither_q.enable    <= wbyte[DITH_EN_BIT];
         dither_q.amplitude <= wbyte[DITH_AMP_BIT];
         dither_q.rounding  <= wbyte[DITH_RND_BIT];
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb begin
      rdata_d = '0;
      case (regIdx)
         IDX_TRIM_B: begin
            rdata_d = busWord(REG_W'(trimB_q));
         end
         IDX_TRIM_C: begin
            rdata_d = busWord(REG_W'(trimC_q));
         end
         IDX_TRIM_D: begin
            rdata_d = busWord(REG_W'(trimD_q));
         end
         IDX_OVERLAP: begin
            rdata_d = busWord(REG_W'(overlapDly_q));
         end
         IDX_STEER: begin
            rdata_d = busWord(REG_W'(steerDly_q));
         end
         IDX_DITHER: begin
            rdata_d = busWord(REG_W'(dither_q));
         end
         IDX_STATUS: begin
            rdata_d[STAT_BUSY_BIT] = timerBusy;
            rdata_d[STAT_OVL_BIT]  = timerOverlap;
            rdata_d[STAT_CAL_BIT]  = calEnable;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // Data is sampled with the ack and cleared otherwise, so the bus idles at zero.
   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_q <= '0;
      end else if (busReq && !ack_q && !wb_we_i) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= '0;
      end
   end

   assign wb_dat_o = rdata_q;

   // ------------------------------------------------------------
   // Core-side retiming
   // ------------------------------------------------------------
   // A single clock serves as core clock; one register stage decouples bus timing.
   always_ff @(posedge clock) begin
      if (reset) begin
         coreCfg_q.overlap <= OVERLAP_RESET;
         coreCfg_q.steer   <= STEER_RESET;
         coreDither_q      <= atsd_dither_s'(DITHER_RESET);
      end else begin
         coreCfg_q.overlap <= overlapDly_q;
         coreCfg_q.steer   <= steerDly_q;
         coreDither_q      <= dither_q;
      end
   end

   // ------------------------------------------------------------
   // Swap timing
   // ------------------------------------------------------------
   atsd_swap_timer uSwapTimer (
      .clock         (clock),
      .reset         (reset),
      .cfg           (coreCfg_q),
      .swapStart     (swapStart),
      .steerSelRaw   (steerSelRaw),
      .overlapActive (timerOverlap),
      .swapBusy      (timerBusy),
      .steerSel      (timerSel)
   );

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   // The trims go straight out; in reset they follow the fuses so termination never sees a zero trim.
   always_ff @(posedge clock) begin
      if (reset) begin
         terminationTrimB <= fuseTrimB;
         terminationTrimC <= fuseTrimC;
         terminationTrimD <= fuseTrimD;
      end else begin
         terminationTrimB <= trimB_q;
         terminationTrimC <= trimC_q;
         terminationTrimD <= trimD_q;
      end
   end

   // Dither controls for the cores.
   always_ff @(posedge clock) begin
      if (reset) begin
         ditherControl <= atsd_dither_s'(DITHER_RESET);
      end else begin
         ditherControl <= coreDither_q;
      end
   end

   // Swap outputs: one extra stage keeps them aligned with each other.
   always_ff @(posedge clock) begin
      if (reset) begin
         swapOverlap <= 1'b0;
         swapBusy    <= 1'b0;
         steerSel    <= 1'b0;
      end else begin
         swapOverlap <= timerOverlap;
         swapBusy    <= timerBusy;
         steerSel    <= timerSel;
      end
   end

endmodule
`default_nettype wire

// >>> testbench/atsd_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module atsd_regs_checker #(
   parameter int unsigned TRIM_W = 8
) (
   // Clock and reset
   input wire logic                        clock,
   input wire logic                        reset,
   // Wishbone slave
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire logic                        wb_we_i,
   input wire logic [atsd_pkg::ADR_W-1:0]  wb_adr_i,
   input wire logic [atsd_pkg::SEL_W-1:0]  wb_sel_i,
   input wire logic [atsd_pkg::DATA_W-1:0] wb_dat_i,
   input wire logic [atsd_pkg::DATA_W-1:0] wb_dat_o,
   input wire logic                        wb_ack_o,
   // Fuse store and sequencer
   input wire logic [TRIM_W-1:0]           fuseTrimB,
   input wire logic [TRIM_W-1:0]           fuseTrimC,
   input wire logic [TRIM_W-1:0]           fuseTrimD,
   input wire logic                        calEnable,
   input wire logic                        swapStart,
   input wire logic                        steerSelRaw,
   // Analog and core controls
   input wire logic [TRIM_W-1:0]           terminationTrimB,
   input wire logic [TRIM_W-1:0]           terminationTrimC,
   input wire logic [TRIM_W-1:0]           terminationTrimD,
   input wire atsd_pkg::atsd_dither_s      ditherControl,
   input wire logic                        swapOverlap,
   input wire logic                        swapBusy,
   input wire logic                        steerSel
);
   import atsd_pkg::*;

   // ----------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------
   logic [7:0]       ovlRun;
   logic [DLY_W-1:0] ovlShadow;
   logic             ovlWrite;

   // A committed write to the overlap register, seen at the ack edge.
   assign ovlWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i[9:2] == IDX_OVERLAP;

   // Shadow of the overlap field; the bench never writes it during a swap, so retiming does not matter.
   always_ff @(posedge clock) begin
      if (reset) begin
         ovlShadow <= OVERLAP_RESET;
      end else if (ovlWrite) begin
         ovlShadow <= wb_dat_i[DLY_W-1:0];
      end
   end

   // Length of the current overlap run in core clock cycles.
   always_ff @(posedge clock) begin
      if (reset || !swapOverlap) begin
         ovlRun <= 8'h00;
      end else begin
         ovlRun <= ovlRun + 8'h01;
      end
   end

   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_ackAnswer;
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ackAnswer: assert property (p_ackAnswer) else $error("no ack one cycle after request");

   property p_ackPulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");

   property p_readIdle;
      !wb_ack_o |-> wb_dat_o == '0;
   endproperty
   a_readIdle: assert property (p_readIdle) else $error("read data not zero outside ack");

   property p_resetLoad;
      $fell(reset) |-> terminationTrimB == fuseTrimB && terminationTrimC == fuseTrimC
                       && terminationTrimD == fuseTrimD && ditherControl == DITHER_RESET;
   endproperty
   a_resetLoad: assert property (p_resetLoad) else $error("controls not loaded at reset");

   property p_trimWrite;
      (wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == IDX_TRIM_B)
         |=> ##1 terminationTrimB == $past(wb_dat_i[7:0], 2);
   endproperty
   a_trimWrite: assert property (p_trimWrite) else $error("trim write not steering output");

   property p_ditherWrite;
      (wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == IDX_DITHER)
         |=> ##2 ditherControl == $past(wb_dat_i[2:0], 3);
   endproperty
   a_ditherWrite: assert property (p_ditherWrite) else $error("dither bits not applied");

   property p_overlapLen;
      $fell(swapOverlap) |-> ovlRun == {2'b00, ovlShadow, 1'b0} + 8'h04;
   endproperty
   a_overlapLen: assert property (p_overlapLen) else $error("overlap length wrong");

   property p_swapAnswer;
      (swapStart && !swapBusy && !swapOverlap) |-> ##[1:3] swapOverlap;
   endproperty
   a_swapAnswer: assert property (p_swapAnswer) else $error("swap start not answered");

   property p_overlapInBusy;
      swapOverlap |-> swapBusy;
   endproperty
   a_overlapInBusy: assert property (p_overlapInBusy) else $error("overlap outside busy");

   property p_idleSelect;
      (!swapBusy && $rose(steerSelRaw)) |-> ##[1:2] steerSel;
   endproperty
   a_idleSelect: assert property (p_idleSelect) else $error("select delayed outside swap");

   c_overlap: cover property ($fell(swapOverlap));
   c_write: cover property (wb_ack_o && wb_we_i);
   c_busySel: cover property (swapBusy && $rose(steerSel));
endmodule

bind atsd_trim_swap_dither_regs atsd_regs_checker #(.TRIM_W(TRIM_W)) u_checker (
   .clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .fuseTrimB(fuseTrimB), .fuseTrimC(fuseTrimC), .fuseTrimD(fuseTrimD), .calEnable(calEnable),
   .swapStart(swapStart), .steerSelRaw(steerSelRaw), .terminationTrimB(terminationTrimB),
   .terminationTrimC(terminationTrimC), .terminationTrimD(terminationTrimD), .ditherControl(ditherControl),
   .swapOverlap(swapOverlap), .swapBusy(swapBusy), .steerSel(steerSel)
);
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import atsd_pkg::*;

   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic                clock;
   logic                reset;
   logic                wbCyc, wbStb, wbWe, wbAck;
   logic [ADR_W-1:0]    wbAdr;
   logic [SEL_W-1:0]    wbSel;
   logic [DATA_W-1:0]   wbDatW, wbDatR, rd;
   logic [7:0]          fuseB, fuseC, fuseD, trimB, trimC, trimD;
   logic                calEnable, swapStart, steerSelRaw, swapOverlap, swapBusy, steerSel;
   atsd_dither_s        dither;
   int                  failures, samplesChecked, dIdle;

   atsd_trim_swap_dither_regs dut (
      .clock(clock), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
      .fuseTrimB(fuseB), .fuseTrimC(fuseC), .fuseTrimD(fuseD), .calEnable(calEnable),
      .swapStart(swapStart), .steerSelRaw(steerSelRaw), .terminationTrimB(trimB),
      .terminationTrimC(trimC), .terminationTrimD(trimD), .ditherControl(dither),
      .swapOverlap(swapOverlap), .swapBusy(swapBusy), .steerSel(steerSel));

   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && samplesChecked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One classic cycle; the request is held until ack is sampled, then released for an idle cycle.
   task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] sel);
      int n;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx, 2'b00};
      wbSel <= sel;
      wbDatW <= wd;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rd = wbDatR;
      check("busAck", wbAck, 1'b1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0, 4'hF);
      check($sformatf("reg_%h", idx), rd, exp);
   endtask

   // Fuse values are set with reset and held stable while it is high.
   task automatic doReset(input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
      fuseB <= b;
      fuseC <= c;
      fuseD <= d;
      reset <= 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
   endtask

   // Runs one swap, measures overlap length and the select delay inside it, and retries a start mid-swap.
   task automatic swapRun(input logic [4:0] d, input logic [4:0] s);
      int n, len, dBusy;
      logic seen;
      bus(1'b1, IDX_OVERLAP, {27'h0, d}, 4'h1);
      bus(1'b1, IDX_STEER, {27'h0, s}, 4'h1);
      repeat (3) @(posedge clock);
      swapStart <= 1'b1;
      @(posedge clock);
      swapStart <= 1'b0;
      n = 0;
      while (swapOverlap !== 1'b1 && n < 10) begin
         @(posedge clock);
         n++;
      end
      steerSelRaw <= 1'b1;
      len = 1;
      dBusy = 0;
      n = 0;
      while (swapOverlap === 1'b1 && n < 200) begin
         swapStart <= (n == 1);
         @(posedge clock);
         n++;
         if (swapOverlap === 1'b1) len++;
         if (steerSel === 1'b1 && dBusy == 0) dBusy = n;
      end
      swapStart <= 1'b0;
      n = 0;
      while (swapBusy === 1'b1 && n < 100) begin
         @(posedge clock);
         n++;
      end
      check("busyTail", n, s + 1);
      steerSelRaw <= 1'b0;
      seen = 1'b0;
      repeat (40) begin
         @(posedge clock);
         seen = seen | (swapOverlap === 1'b1);
      end
      check("overlapCycles", len, 4 + 2 * d);
      check("busySelectDelay", dBusy, dIdle + s);
      check("startIgnored", seen, 1'b0);
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      int n;
      {reset, wbCyc, wbStb, wbWe, calEnable, swapStart, steerSelRaw} = 7'h40;
      {wbAdr, wbSel, wbDatW} = '0;
      {fuseB, fuseC, fuseD} = 24'h5AC33C;
      doReset(8'h5A, 8'hC3, 8'h3C);
      rdChk(IDX_TRIM_B, 32'h5A);
      rdChk(IDX_TRIM_C, 32'hC3);
      rdChk(IDX_TRIM_D, 32'h3C);
      rdChk(IDX_OVERLAP, 32'h08);
      rdChk(IDX_STEER, 32'h07);
      rdChk(IDX_DITHER, 32'h00);
      rdChk(IDX_STATUS, 32'h0);
      calEnable <= 1'b1;
      rdChk(IDX_STATUS, 32'h4);
      calEnable <= 1'b0;
      bus(1'b1, IDX_TRIM_B, 32'hFFFF_FFA5, 4'hF);
      rdChk(IDX_TRIM_B, 32'hA5);
      check("trimB", trimB, 8'hA5);
      bus(1'b1, IDX_TRIM_C, 32'h11, 4'hE);
      rdChk(IDX_TRIM_C, 32'hC3);
      bus(1'b1, IDX_TRIM_D, 32'h96, 4'h1);
      rdChk(IDX_TRIM_D, 32'h96);
      check("trimD", trimD, 8'h96);
      bus(1'b1, IDX_OVERLAP, 32'h1F, 4'h1);
      rdChk(IDX_OVERLAP, 32'h1F);
      bus(1'b1, IDX_STEER, 32'h1F, 4'h1);
      rdChk(IDX_STEER, 32'h1F);
      bus(1'b1, 8'h90, 32'hFF, 4'h1);
      rdChk(8'h90, 32'h0);
      // Every dither combination reaches the core controls.
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, IDX_DITHER, 32'(i), 4'h1);
         repeat (2) @(posedge clock);
         check("ditherControl", dither, i);
      end
      rdChk(IDX_DITHER, 32'h07);
      // Select delay with no swap running, used as the reference.
      steerSelRaw <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (steerSel !== 1'b1 && n < 40);
      dIdle = n;
      check("idleSelectDelay", dIdle inside {2, 3}, 1'b1);
      steerSelRaw <= 1'b0;
      repeat (40) @(posedge clock);
      swapRun(5'd0, 5'd0);
      swapRun(5'd7, 5'd5);
      swapRun(5'd31, 5'd31);
      // A second reset reloads the trims from changed fuses.
      doReset(8'h81, 8'h18, 8'hE7);
      check("trimC", trimC, 8'h18);
      rdChk(IDX_TRIM_B, 32'h81);
      rdChk(IDX_TRIM_D, 32'hE7);
      rdChk(IDX_OVERLAP, 32'h08);
      give_verdict();
   end

   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      repeat (8000) @(posedge clock);
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
